// ### hw/spis_evt_pkg.sv
// Shared constants for the SPI slave event, shortcut and interrupt-enable register bank.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address and one clock.
package spis_evt_pkg;

	// ------------------------------------------------------------
	// Bus geometry and answers
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_SEMAPHORE_RELEASE_TASK = 12'h028;
	localparam logic [11:0] OFS_TRANSACTION_END_EVENT = 12'h104;
	localparam logic [11:0] OFS_RX_BUFFER_END_EVENT = 12'h110;
	localparam logic [11:0] OFS_SEMAPHORE_ACQUIRED_EVENT = 12'h128;
	localparam logic [11:0] OFS_EVENT_TASK_SHORTCUTS = 12'h200;
	localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h304;
	localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;

	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int NUM_EVENTS = 3;
	localparam int EVENT_BIT = 0;
	localparam int TASK_TRIGGER_BIT = 0;
	localparam int SHORT_END_ACQUIRE_BIT = 0;
	localparam int IRQ_END_BIT = 0;
	localparam int IRQ_RX_BUFFER_END_BIT = 1;
	localparam int IRQ_ACQUIRED_BIT = 2;
	localparam logic TASK_TRIGGER = 1'h1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [2:0] RST_EVENTS = 3'h0;
	localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;
	localparam logic RST_SHORTCUT = 1'h0;

	// ------------------------------------------------------------
	// Write channel states of the bus slave, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		WR_IDLE = 4'h1,
		WR_HAVE_ADDR = 4'h2,
		WR_HAVE_DATA = 4'h4,
		WR_RESP = 4'h8
	} wr_state_e;

	// True for every offset that holds a register
	function automatic logic reg_mapped(input logic [11:0] addr);
		reg_mapped = (addr == OFS_SEMAPHORE_RELEASE_TASK) ||
			(addr == OFS_TRANSACTION_END_EVENT) ||
			(addr == OFS_RX_BUFFER_END_EVENT) ||
			(addr == OFS_SEMAPHORE_ACQUIRED_EVENT) ||
			(addr == OFS_EVENT_TASK_SHORTCUTS) ||
			(addr == OFS_IRQ_ENABLE_SET) ||
			(addr == OFS_IRQ_ENABLE_CLEAR);
	endfunction

endpackage

// ### hw/axil_reg_port.sv
// AXI4-Lite slave front end: turns bus writes into a one-cycle write pulse and
// answers reads from a combinational read mux supplied by the register bank.
// Assumes one clock, active-low asynchronous reset, one write and one read at a time.
module axil_reg_port (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wrPulse,
	output logic [11:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic [31:0] rdData
);

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	spis_evt_pkg::wr_state_e wrState; // Which halves of a write are held
	spis_evt_pkg::wr_state_e next_wrState;
	logic [11:0] next_wrAddr;
	logic [31:0] next_wrData;
	logic [3:0] next_wrStrb;
	logic next_wrPulse;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic awTake; // Address beat accepted this edge
	logic wTake; // Data beat accepted this edge

	// Ready only for a half not yet held; nothing taken while a response waits
	assign awready = (wrState == spis_evt_pkg::WR_IDLE) || (wrState == spis_evt_pkg::WR_HAVE_DATA);
	assign wready = (wrState == spis_evt_pkg::WR_IDLE) || (wrState == spis_evt_pkg::WR_HAVE_ADDR);
	assign awTake = awvalid && awready;
	assign wTake = wvalid && wready;

	// Next write state; the pulse and the response are raised together
	always_comb begin
		logic [11:0] respAddr;
		respAddr = wrAddr;
		next_wrState = wrState;
		next_wrAddr = wrAddr;
		next_wrData = wrData;
		next_wrStrb = wrStrb;
		next_wrPulse = 1'h0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (awTake) begin
			next_wrAddr = awaddr;
			respAddr = awaddr;
		end
		if (wTake) begin
			next_wrData = wdata;
			next_wrStrb = wstrb;
		end
		case (wrState)
			spis_evt_pkg::WR_IDLE: begin
				if (awTake && wTake) begin
					next_wrState = spis_evt_pkg::WR_RESP;
				end else if (awTake) begin
					next_wrState = spis_evt_pkg::WR_HAVE_ADDR;
				end else if (wTake) begin
					next_wrState = spis_evt_pkg::WR_HAVE_DATA;
				end
			end
			spis_evt_pkg::WR_HAVE_ADDR: begin
				if (wTake) begin
					next_wrState = spis_evt_pkg::WR_RESP;
				end
			end
			spis_evt_pkg::WR_HAVE_DATA: begin
				if (awTake) begin
					next_wrState = spis_evt_pkg::WR_RESP;
				end
			end
			spis_evt_pkg::WR_RESP: begin
				// Response leaves once the master takes it
				if (bready) begin
					next_bvalid = 1'h0;
					next_wrState = spis_evt_pkg::WR_IDLE;
				end
			end
			default: begin
				next_wrState = spis_evt_pkg::WR_IDLE;
			end
		endcase
		// Entering the response state performs the write exactly once
		if (wrState != spis_evt_pkg::WR_RESP && next_wrState == spis_evt_pkg::WR_RESP) begin
			next_wrPulse = 1'h1;
			next_bvalid = 1'h1;
			next_bresp = spis_evt_pkg::reg_mapped(respAddr) ?
				spis_evt_pkg::RESP_OKAY : spis_evt_pkg::RESP_SLVERR;
		end
	end

	// Write channel registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wrState <= spis_evt_pkg::WR_IDLE;
			wrAddr <= 12'h000;
			wrData <= spis_evt_pkg::RST_WORD;
			wrStrb <= 4'h0;
			wrPulse <= 1'h0;
			bvalid <= 1'h0;
			bresp <= spis_evt_pkg::RESP_OKAY;
		end else begin
			wrState <= next_wrState;
			wrAddr <= next_wrAddr;
			wrData <= next_wrData;
			wrStrb <= next_wrStrb;
			wrPulse <= next_wrPulse;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// One read at a time: a new address waits until the data is taken
	assign arready = !rvalid;

	// Capture the mux at the address edge; reads have no side effects
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (arvalid && arready) begin
			next_rvalid = 1'h1;
			next_rdata = rdData;
			next_rresp = spis_evt_pkg::reg_mapped(araddr) ?
				spis_evt_pkg::RESP_OKAY : spis_evt_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			next_rvalid = 1'h0;
		end
	end

	// Read channel registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rvalid <= 1'h0;
			rdata <= spis_evt_pkg::RST_WORD;
			rresp <= spis_evt_pkg::RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

endmodule

// ### hw/spi_slave_event_irq_regs.sv
// Event, shortcut, task and interrupt-enable registers of an SPI slave that
// shares its buffers with the processor through a semaphore.
// Assumes the semaphore arbiter and the serial engine run on core_clk and give
// one-cycle event pulses; software reaches the bank over AXI4-Lite.

module spi_slave_event_irq_regs (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic transactionEnd,
	input wire logic rxBufferEnd,
	input wire logic semaphoreGranted,
	output logic releaseTask,
	output logic acquireTask,
	output logic irq
);

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	logic wrPulse; // One cycle per completed bus write
	logic [11:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic [31:0] rdData; // Combinational read mux for araddr

	axil_reg_port busPort (
		.core_clk(core_clk),
		.resetn(resetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wrPulse(wrPulse),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.rdData(rdData)
	);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [2:0] evt; // Event bits: end, rx buffer end, acquired
	logic [2:0] next_evt;
	logic [2:0] irqEn; // Interrupt enables, same layout as evt
	logic [2:0] next_irqEn;
	logic shortcut; // End-to-acquire shortcut
	logic next_shortcut;
	logic next_releaseTask;
	logic next_acquireTask;
	logic next_irq;
	logic [2:0] hwEvt; // Event pulses from the engine, by bit
	logic byte0Wr; // Write reaches the byte holding every field

	// Event offsets in bit order
	localparam logic [11:0] EVT_OFS [3] = '{
		spis_evt_pkg::OFS_TRANSACTION_END_EVENT,
		spis_evt_pkg::OFS_RX_BUFFER_END_EVENT,
		spis_evt_pkg::OFS_SEMAPHORE_ACQUIRED_EVENT
	};

	// ------------------------------------------------------------
	// Event bits
	// ------------------------------------------------------------
	// Engine pulses already run on core_clk, so they need no synchroniser
	assign hwEvt[spis_evt_pkg::IRQ_END_BIT] = transactionEnd;
	assign hwEvt[spis_evt_pkg::IRQ_RX_BUFFER_END_BIT] = rxBufferEnd;
	assign hwEvt[spis_evt_pkg::IRQ_ACQUIRED_BIT] = semaphoreGranted;
	// Every field sits in byte 0; a write with that lane off changes nothing
	assign byte0Wr = wrPulse && wrStrb[0];

	// Per event: hardware set wins over a software write in the same cycle,
	// so an event that lands while software clears it is never lost
	for (genvar i = 0; i < spis_evt_pkg::NUM_EVENTS; i++) begin : gEvt
		assign next_evt[i] = hwEvt[i] ||
			((byte0Wr && wrAddr == EVT_OFS[i]) ? wrData[spis_evt_pkg::EVENT_BIT] : evt[i]);
	end

	// ------------------------------------------------------------
	// Enables, shortcut and tasks
	// ------------------------------------------------------------
	// Enables, shortcut, task pulses and the interrupt level
	always_comb begin
		logic [2:0] setMask;
		logic [2:0] clrMask;
		setMask = 3'h0;
		clrMask = 3'h0;
		if (byte0Wr && wrAddr == spis_evt_pkg::OFS_IRQ_ENABLE_SET) begin
			setMask = wrData[2:0];
		end
		if (byte0Wr && wrAddr == spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR) begin
			clrMask = wrData[2:0];
		end
		// Set and clear are separate offsets, so one write never does both
		next_irqEn = (irqEn | setMask) & ~clrMask;
		if (byte0Wr && wrAddr == spis_evt_pkg::OFS_EVENT_TASK_SHORTCUTS) begin
			next_shortcut = wrData[spis_evt_pkg::SHORT_END_ACQUIRE_BIT];
		end else begin
			next_shortcut = shortcut;
		end
		// Release is a write-only trigger; writing zero does nothing
		next_releaseTask = byte0Wr && wrAddr == spis_evt_pkg::OFS_SEMAPHORE_RELEASE_TASK &&
			wrData[spis_evt_pkg::TASK_TRIGGER_BIT] == spis_evt_pkg::TASK_TRIGGER;
		// Uses the shortcut as it stood when the end pulse arrived
		next_acquireTask = transactionEnd && shortcut;
		// Registered from next values so irq tracks evt and irqEn with no lag
		next_irq = |(next_evt & next_irqEn);
	end

	// Register bank flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			// Every bit clears: no event, no enable, shortcut off
			evt <= spis_evt_pkg::RST_EVENTS;
			irqEn <= spis_evt_pkg::RST_IRQ_ENABLE;
			shortcut <= spis_evt_pkg::RST_SHORTCUT;
			releaseTask <= 1'h0;
			acquireTask <= 1'h0;
			irq <= 1'h0;
		end else begin
			// Plain registering; every decision lives in the event loop and the process above
			evt <= next_evt;
			irqEn <= next_irqEn;
			shortcut <= next_shortcut;
			releaseTask <= next_releaseTask;
			acquireTask <= next_acquireTask;
			irq <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// Unused bits and the write-only task read as zero
	always_comb begin
		rdData = spis_evt_pkg::RST_WORD;
		case (araddr)
			// Event bits read back in bit 0
			spis_evt_pkg::OFS_TRANSACTION_END_EVENT: begin
				rdData[spis_evt_pkg::EVENT_BIT] = evt[spis_evt_pkg::IRQ_END_BIT];
			end
			spis_evt_pkg::OFS_RX_BUFFER_END_EVENT: begin
				rdData[spis_evt_pkg::EVENT_BIT] = evt[spis_evt_pkg::IRQ_RX_BUFFER_END_BIT];
			end
			spis_evt_pkg::OFS_SEMAPHORE_ACQUIRED_EVENT: begin
				rdData[spis_evt_pkg::EVENT_BIT] = evt[spis_evt_pkg::IRQ_ACQUIRED_BIT];
			end
			spis_evt_pkg::OFS_EVENT_TASK_SHORTCUTS: begin
				rdData[spis_evt_pkg::SHORT_END_ACQUIRE_BIT] = shortcut;
			end
			spis_evt_pkg::OFS_IRQ_ENABLE_SET, spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR: begin
				rdData[2:0] = irqEn;
			end
			default: begin
				rdData = spis_evt_pkg::RST_WORD;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// All checks share the bank clock; none runs while reset is held
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// ------------------------------------------------------------
	// Release task
	// ------------------------------------------------------------
	// A release write gives exactly one pulse, and nothing else gives one
	a_release_pulse: assert property (byte0Wr && wrData[0] &&
		wrAddr == spis_evt_pkg::OFS_SEMAPHORE_RELEASE_TASK |=> releaseTask ##1 !releaseTask)
		else $error("release task did not pulse once");
	a_release_quiet: assert property (!(byte0Wr && wrData[0] &&
		wrAddr == spis_evt_pkg::OFS_SEMAPHORE_RELEASE_TASK) |=> !releaseTask)
		else $error("release task pulsed without a write");

	// ------------------------------------------------------------
	// Event registers
	// ------------------------------------------------------------
	// A bit moves only for its own pulse or a write to its own offset
	a_event_hold: assert property (!transactionEnd &&
		!(wrPulse && wrAddr == spis_evt_pkg::OFS_TRANSACTION_END_EVENT) |=> $stable(evt[0]))
		else $error("end event changed without cause");
	a_rx_end_hold: assert property (!rxBufferEnd &&
		!(wrPulse && wrAddr == spis_evt_pkg::OFS_RX_BUFFER_END_EVENT) |=> $stable(evt[1]))
		else $error("rx buffer end event changed without cause");
	a_acquired_hold: assert property (!semaphoreGranted &&
		!(wrPulse && wrAddr == spis_evt_pkg::OFS_SEMAPHORE_ACQUIRED_EVENT) |=>
		$stable(evt[2]))
		else $error("acquired event changed without cause");
	// Read data is the bit as it stood at the address edge
	a_event_read: assert property (arvalid && arready &&
		araddr == spis_evt_pkg::OFS_TRANSACTION_END_EVENT |=>
		rvalid && rdata == {31'h0, $past(evt[0])})
		else $error("end event read back wrong");
	a_rx_end_read: assert property (arvalid && arready &&
		araddr == spis_evt_pkg::OFS_RX_BUFFER_END_EVENT |=>
		rvalid && rdata == {31'h0, $past(evt[1])})
		else $error("rx buffer end event read back wrong");
	a_acquired_read: assert property (arvalid && arready &&
		araddr == spis_evt_pkg::OFS_SEMAPHORE_ACQUIRED_EVENT |=>
		rvalid && rdata == {31'h0, $past(evt[2])})
		else $error("acquired event read back wrong");
	// Hardware pulses win over any write in the same cycle
	a_end_set: assert property (transactionEnd |=> evt[0])
		else $error("transaction end event not set");
	a_rx_end_set: assert property (rxBufferEnd |=> evt[1])
		else $error("rx buffer end event not set");
	a_acquired_set: assert property (semaphoreGranted |=> evt[2])
		else $error("acquired event not set");
	// Software writing a one sets the bit just as a pulse would
	a_event_write: assert property (byte0Wr && wrData[0] &&
		wrAddr == spis_evt_pkg::OFS_TRANSACTION_END_EVENT |=> evt[0])
		else $error("end event write of one lost");

	// ------------------------------------------------------------
	// Shortcut
	// ------------------------------------------------------------
	// The acquire pulse follows an end pulse only while the shortcut is on
	a_shortcut_fire: assert property (transactionEnd && shortcut |=> acquireTask)
		else $error("shortcut did not trigger acquire");
	a_shortcut_quiet: assert property (!(transactionEnd && shortcut) |=> !acquireTask)
		else $error("acquire triggered without shortcut");
	// The stored bit is the one last written
	a_shortcut_store: assert property (byte0Wr &&
		wrAddr == spis_evt_pkg::OFS_EVENT_TASK_SHORTCUTS |=> shortcut == $past(wrData[0]))
		else $error("shortcut bit not stored");

	// ------------------------------------------------------------
	// Interrupt enables and level
	// ------------------------------------------------------------
	// Ones change their own enable; zeros leave the others alone
	a_enable_set: assert property (byte0Wr &&
		wrAddr == spis_evt_pkg::OFS_IRQ_ENABLE_SET |=>
		(irqEn & $past(wrData[2:0])) == $past(wrData[2:0]) &&
		(irqEn & ~$past(wrData[2:0])) == ($past(irqEn) & ~$past(wrData[2:0])))
		else $error("enable set wrong");
	a_enable_clear: assert property (byte0Wr &&
		wrAddr == spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR |=>
		(irqEn & $past(wrData[2:0])) == 3'h0 &&
		(irqEn & ~$past(wrData[2:0])) == ($past(irqEn) & ~$past(wrData[2:0])))
		else $error("enable clear wrong");
	a_enable_quiet: assert property (!(wrPulse &&
		(wrAddr == spis_evt_pkg::OFS_IRQ_ENABLE_SET ||
		wrAddr == spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR)) |=> $stable(irqEn))
		else $error("enables changed without a write");
	// A write with byte lane 0 off leaves enables and shortcut alone
	a_lane_ignored: assert property (wrPulse && !wrStrb[0] |=>
		$stable(irqEn) && $stable(shortcut))
		else $error("write without byte lane 0 took effect");
	// Both enable offsets read back the one set of enables
	a_enable_read: assert property (arvalid && arready &&
		(araddr == spis_evt_pkg::OFS_IRQ_ENABLE_SET ||
		araddr == spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR) |=> rdata == {29'h0, $past(irqEn)})
		else $error("enable read back wrong");
	// Registered from next values, so the level never lags its inputs
	a_irq_level: assert property (irq == |(evt & irqEn))
		else $error("interrupt level mismatch");

	// ------------------------------------------------------------
	// Coverage of the main scenarios
	// ------------------------------------------------------------
	c_release: cover property (releaseTask);
	c_shortcut_acquire: cover property (transactionEnd && shortcut ##1 acquireTask);
	c_irq_rise: cover property (!irq ##1 irq);
	c_set_clash: cover property (transactionEnd && wrPulse &&
		wrAddr == spis_evt_pkg::OFS_TRANSACTION_END_EVENT && !wrData[0]);
	c_lane_off: cover property (wrPulse && !wrStrb[0]);

endmodule

// ### sim/spi_master_model.sv
// Behavioural stand-in for the serial engine and the semaphore arbiter beside the bank.
// Assumes the bench raises each request for exactly one core_clk cycle.
module spi_master_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic endReq,
	input wire logic rxReq,
	input wire logic grantReq,
	input wire logic acquireTask,
	output logic transactionEnd,
	output logic rxBufferEnd,
	output logic semaphoreGranted
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Event pulses
	// ------------------------------------------------------------
	// Every event is a one-cycle pulse one edge after its request.
	// An acquire is granted at once, as an idle arbiter would, so the
	// shortcut path can be followed all the way to the acquired event.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			transactionEnd <= 1'h0;
			rxBufferEnd <= 1'h0;
			semaphoreGranted <= 1'h0;
		end else begin
			transactionEnd <= endReq;
			rxBufferEnd <= rxReq;
			semaphoreGranted <= grantReq | acquireTask;
		end
	end
endmodule

// ### sim/spi_slave_event_irq_regs_bench.sv
// Self-checking bench for the event, shortcut, task and interrupt-enable bank.
// Assumes the design package and the partner model are compiled first.
module spi_slave_event_irq_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic core_clk = 1'h0, resetn = 1'h0;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, r;
	logic transactionEnd, rxBufferEnd, semaphoreGranted;
	logic endReq, rxReq, grantReq, releaseTask, acquireTask, irq;
	int errTotal = 0, cmpCount = 0, cycles = 0, relCnt = 0, acqCnt = 0;

	// Ordinary cases: write a register, then read one back
	typedef struct {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] rd;} row_s;
	row_s rows[7] = '{
		'{spis_evt_pkg::OFS_IRQ_ENABLE_SET, 32'h5, spis_evt_pkg::OFS_IRQ_ENABLE_SET, 32'h5},
		'{spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h1, spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h4},
		'{spis_evt_pkg::OFS_IRQ_ENABLE_SET, 32'h0, spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h4},
		'{spis_evt_pkg::OFS_EVENT_TASK_SHORTCUTS, 32'h1, spis_evt_pkg::OFS_EVENT_TASK_SHORTCUTS, 32'h1},
		'{spis_evt_pkg::OFS_TRANSACTION_END_EVENT, 32'h1, spis_evt_pkg::OFS_TRANSACTION_END_EVENT, 32'h1},
		'{spis_evt_pkg::OFS_TRANSACTION_END_EVENT, 32'h0, spis_evt_pkg::OFS_TRANSACTION_END_EVENT, 32'h0},
		'{spis_evt_pkg::OFS_SEMAPHORE_RELEASE_TASK, 32'h1, spis_evt_pkg::OFS_SEMAPHORE_RELEASE_TASK, 32'h0}
	};
	logic [11:0] regs[7] = '{12'h028, 12'h104, 12'h110, 12'h128, 12'h200, 12'h304, 12'h308};

	// ------------------------------------------------------------
	// Design and partner
	// ------------------------------------------------------------
	spi_slave_event_irq_regs u_dut (.core_clk, .resetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .transactionEnd, .rxBufferEnd, .semaphoreGranted,
		.releaseTask, .acquireTask, .irq);
	spi_master_model u_far (.core_clk, .resetn, .endReq, .rxReq, .grantReq, .acquireTask,
		.transactionEnd, .rxBufferEnd, .semaphoreGranted);

	// Clock, task pulse counters and the hang limit
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		relCnt += int'(releaseTask === 1'h1);
		acqCnt += int'(acquireTask === 1'h1);
		if (cycles == 5000) begin
			errTotal++;
			results();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Handshakes are judged at the falling edge, where everything has settled,
	// and acted on at the following rising edge
	task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
			output logic [1:0] resp);
		logic ta, tw, tb;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		tb = 1'h0;
		while (!tb) begin
			@(negedge core_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			resp = bresp;
			@(posedge core_clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end
		bready <= 1'h0;
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic ta, tb;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		tb = 1'h0;
		while (!tb) begin
			@(negedge core_clk);
			ta = arvalid && arready;
			tb = rvalid && rready;
			v = rdata;
			resp = rresp;
			@(posedge core_clk);
			if (ta) arvalid <= 1'h0;
		end
		rready <= 1'h0;
	endtask

	// One-cycle request to the partner, in order end, rx buffer end, grant
	task automatic pulse(input logic [2:0] k);
		@(posedge core_clk);
		{endReq, rxReq, grantReq} <= k;
		@(posedge core_clk);
		{endReq, rxReq, grantReq} <= 3'h0;
		repeat (6) @(negedge core_clk);
	endtask

	// Registered irq moves at the same edge as the register a write changes
	task automatic settle();
		repeat (2) @(negedge core_clk);
	endtask

	task automatic results();
		if (errTotal == 0 && cmpCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready, endReq, rxReq, grantReq} = '0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'h1;
		foreach (regs[i]) begin
			axr(regs[i], d, r);
			chk(d, 32'h0);
		end
		chk(irq, 1'h0);
		foreach (rows[i]) begin
			axw(rows[i].wa, rows[i].wd, 4'hF, r);
			chk(r, spis_evt_pkg::RESP_OKAY);
			axr(rows[i].ra, d, r);
			chk(d, rows[i].rd);
		end
		settle();
		chk(relCnt, 1);
		// Unmapped place and a write with no byte lane enabled
		axw(12'h0FC, 32'h1, 4'hF, r);
		chk(r, spis_evt_pkg::RESP_SLVERR);
		axr(12'h0FC, d, r);
		chk(r, spis_evt_pkg::RESP_SLVERR);
		axw(spis_evt_pkg::OFS_SEMAPHORE_RELEASE_TASK, 32'h1, 4'h0, r);
		settle();
		chk(relCnt, 1);
		// Receive buffer end: masked, unmasked, then cleared by software
		axw(spis_evt_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h7, 4'hF, r);
		pulse(3'h2);
		chk(irq, 1'h0);
		axr(spis_evt_pkg::OFS_RX_BUFFER_END_EVENT, d, r);
		chk(d, 32'h1);
		axw(spis_evt_pkg::OFS_IRQ_ENABLE_SET, 32'h2, 4'hF, r);
		settle();
		chk(irq, 1'h1);
		axw(spis_evt_pkg::OFS_RX_BUFFER_END_EVENT, 32'h0, 4'hF, r);
		settle();
		chk(irq, 1'h0);
		// Transaction end with the shortcut on re-acquires the semaphore
		axw(spis_evt_pkg::OFS_IRQ_ENABLE_SET, 32'h1, 4'hF, r);
		pulse(3'h4);
		chk(acqCnt, 1);
		chk(irq, 1'h1);
		axr(spis_evt_pkg::OFS_TRANSACTION_END_EVENT, d, r);
		chk(d, 32'h1);
		axr(spis_evt_pkg::OFS_SEMAPHORE_ACQUIRED_EVENT, d, r);
		chk(d, 32'h1);
		// Shortcut off: no automatic acquire; a plain grant still sets its event
		axw(spis_evt_pkg::OFS_EVENT_TASK_SHORTCUTS, 32'h0, 4'hF, r);
		axw(spis_evt_pkg::OFS_SEMAPHORE_ACQUIRED_EVENT, 32'h0, 4'hF, r);
		pulse(3'h4);
		chk(acqCnt, 1);
		pulse(3'h1);
		axr(spis_evt_pkg::OFS_SEMAPHORE_ACQUIRED_EVENT, d, r);
		chk(d, 32'h1);
		// Reset in mid-run returns enables, shortcut and events to zero
		axw(spis_evt_pkg::OFS_EVENT_TASK_SHORTCUTS, 32'h1, 4'hF, r);
		resetn <= 1'h0;
		@(posedge core_clk);
		resetn <= 1'h1;
		settle();
		chk(irq, 1'h0);
		foreach (regs[i]) begin
			axr(regs[i], d, r);
			chk(d, 32'h0);
		end
		results();
	end
endmodule
